// ### hdl/port_status_pkg.sv
// Package: register map, field layout, encodings and types for the port status bank
package port_status_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_PORTS = 3;
  localparam int SPEED_W = 3;
  localparam int TALLY_W = 8;

  // ==========================================================================
  // Speed encoding, same for ceiling and capability
  localparam logic [2:0] SPEED_S100 = 3'h0;
  localparam logic [2:0] SPEED_S200 = 3'h1;
  localparam logic [2:0] SPEED_S400 = 3'h2;
  localparam logic [2:0] SPEED_S800 = 3'h3;
  localparam logic [2:0] SPEED_S1600 = 3'h4;
  localparam logic [2:0] SPEED_S3200 = 3'h5;
  localparam logic [2:0] SPEED_TOP_LEGAL = SPEED_S3200;
  localparam logic [7:0] TALLY_MAX = 8'hff;

  // ==========================================================================
  // Byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFS_PORT0 = 8'h00;   // Ports at 0x00, 0x04, 0x08
  localparam logic [7:0] OFS_TALLY0 = 8'h10;  // Error tallies at 0x10, 0x14, 0x18
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_SLEEP_PERMIT = 8'h28;

  // ==========================================================================
  // Field positions in a port status word
  localparam int POS_CEIL = 0;    // [2:0] speed ceiling, RW
  localparam int POS_PLUG = 3;    // plug present, RO
  localparam int POS_CAP = 4;     // [6:4] hardware rate limit, RO
  localparam int POS_UNST = 7;    // link unstable, W1C
  localparam int POS_BSIG = 8;    // b signaling active, RO
  localparam int POS_DORM = 9;    // dormant, RO
  localparam int POS_LEGACY = 10; // active in legacy mode, RO
  localparam int POS_PERMIT = 11; // sleep permit copy, RO here

  // ==========================================================================
  // Reset values
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [2:0] SLEEP_PERMIT_RESET = 3'h0;

  // Per-port events from the line logic
  typedef struct packed {
    logic negFail;      // Speed negotiation failed
    logic syncFail;     // Synchronisation failed
    logic badSymbol;    // Invalid code word received
  } port_event_t;

  // Per-port line state
  typedef struct packed {
    logic connected;    // Debounced connection
    logic receiveValid; // Receive valid
    logic bSignaling;   // Port runs B signaling
    logic sleepReq;     // Line logic wants to sleep
    logic newBConn;     // New B connection being trained
  } port_line_t;

  // Bus FSM states
  typedef enum logic [0:0] {BUS_IDLE, BUS_DATA} bus_state_t;

endpackage

// ### hdl/port_status_regs.sv
// Port status register bank with AHB-Lite slave and interrupt
// Operation
// - Speed code 000..101 ascending, 110/111 reserved
// - Too-high ceiling write stores port maximum
// - Ceiling used only for B-only new connection
// - Bilingual port fixed at S400, ignores writes
// - Reset loads ceiling with port maximum
// - Plug present flag always reads one
// - Read-only capability field, same encoding
// - Negotiation or sync failure sets unstable flag
// - Writing one clears unstable flag
// - B indicator one only in B signaling
// - Legacy active when connected, valid, not B
// - Eight-bit error tally saturates at 255
// - Reading error tally clears it
// - Dormant flag one while port sleeps
// - Sleep entered only when permitted
// - Per-port sleep permit loaded from strap
`timescale 1ns/100ps
`default_nettype none
module port_status_regs #(
  parameter logic [8:0] PORT_CAP = {port_status_pkg::SPEED_S400, port_status_pkg::SPEED_S400,
                                    port_status_pkg::SPEED_S400}, // Per-port capability
  parameter logic [2:0] PORT_BONLY = 3'h0                         // 1 = B-only, 0 = bilingual
) (
  input wire logic mclk,                                    // 20 MHz clock
  input wire logic resetn,                                  // Async reset, active low
  input wire logic hsel,                                    // Slave select
  input wire logic [31:0] haddr,                            // Address
  input wire logic [1:0] htrans,                            // Transfer type
  input wire logic hwrite,                                  // Write
  input wire logic [2:0] hsize,                             // Size
  input wire logic [31:0] hwdata,                           // Write data
  input wire logic hready,                                  // Bus ready
  output logic [31:0] hrdata,                               // Read data
  output logic hreadyout,                                   // Slave ready
  output logic hresp,                                       // Always OKAY
  input wire logic sleepStrap,                              // Sleep permit strap
  input wire port_status_pkg::port_line_t [2:0] lineState,  // Line state per port
  input wire port_status_pkg::port_event_t [2:0] lineEvent, // Event pulses per port
  output logic [8:0] trainSpeed,                            // Speed to train per port
  output logic [2:0] portDormant,                           // Sleep state per port
  output logic irq                                          // Level interrupt
);
  import port_status_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic [2:0] clampSpeed(input logic [2:0] req, input logic [2:0] cap);
    clampSpeed = (req > cap) ? cap : req;
  endfunction

  function automatic logic [2:0] capOf(input int p);
    capOf = PORT_CAP[p*SPEED_W +: SPEED_W];
  endfunction

  // ==========================================================================
  // Bus slave
  bus_state_t busState_reg;
  logic [7:0] addr_reg;
  logic write_reg;
  logic [2:0] ceil_reg [NUM_PORTS];
  logic [2:0] unstable_reg;
  logic [2:0] dormant_reg;
  logic [7:0] tally_reg [NUM_PORTS];
  logic [2:0] irqStatus_reg;
  logic [2:0] irqMask_reg;
  logic [2:0] permit_reg;
  logic strapDone_reg;
  logic [31:0] rdata_next;
  logic wrStrobe;
  logic rdStrobe;
  logic addrPhase;

  assign addrPhase = hsel && hready && htrans[1];
  assign wrStrobe = (busState_reg == BUS_DATA) && write_reg;
  assign rdStrobe = addrPhase && !hwrite;

  // Capture the address phase; zero-wait answers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busState_reg <= BUS_IDLE;
      addr_reg <= 8'h00;
      write_reg <= 1'b0;
    end else begin
      case (busState_reg)
        BUS_IDLE: begin
          if (addrPhase) begin
            busState_reg <= BUS_DATA;
          end
        end
        BUS_DATA: begin
          if (!addrPhase) begin
            busState_reg <= BUS_IDLE;
          end
        end
        default: busState_reg <= BUS_IDLE;
      endcase
      if (addrPhase) begin
        addr_reg <= haddr[7:0];
        write_reg <= hwrite;
      end else begin
        write_reg <= 1'b0;
      end
    end
  end

  // Read mux, sampled at the address phase
  always_comb begin
    rdata_next = 32'h0000_0000;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (haddr[7:0] == OFS_PORT0 + 8'(4*p)) begin
        rdata_next[POS_CEIL +: 3] = ceil_reg[p];
        rdata_next[POS_PLUG] = 1'b1;
        rdata_next[POS_CAP +: 3] = capOf(p);
        rdata_next[POS_UNST] = unstable_reg[p];
        rdata_next[POS_BSIG] = lineState[p].bSignaling;
        rdata_next[POS_DORM] = dormant_reg[p];
        rdata_next[POS_LEGACY] = lineState[p].connected && lineState[p].receiveValid
                                 && !lineState[p].bSignaling;
        rdata_next[POS_PERMIT] = permit_reg[p];
      end
      if (haddr[7:0] == OFS_TALLY0 + 8'(4*p)) begin
        rdata_next[7:0] = tally_reg[p];
      end
    end
    if (haddr[7:0] == OFS_IRQ_STATUS) begin
      rdata_next[2:0] = irqStatus_reg;
    end
    if (haddr[7:0] == OFS_IRQ_MASK) begin
      rdata_next[2:0] = irqMask_reg;
    end
    if (haddr[7:0] == OFS_SLEEP_PERMIT) begin
      rdata_next[2:0] = permit_reg;
    end
  end

  // Read data register; unmapped reads return zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rdStrobe) begin
      hrdata <= rdata_next;
    end
  end

  // Never wait, never error
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================================
  // Speed ceiling per port
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        ceil_reg[p] <= PORT_CAP[p*SPEED_W +: SPEED_W];
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!PORT_BONLY[p]) begin
          ceil_reg[p] <= SPEED_S400;
        end else if (wrStrobe && addr_reg == OFS_PORT0 + 8'(4*p)) begin
          ceil_reg[p] <= clampSpeed(hwdata[POS_CEIL +: 3], capOf(p));
        end
      end
    end
  end

  // Speed to train with, latched at a new B connection
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trainSpeed <= {SPEED_S400, SPEED_S400, SPEED_S400};
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (lineState[p].newBConn) begin
          trainSpeed[p*SPEED_W +: SPEED_W] <= PORT_BONLY[p] ? ceil_reg[p] : SPEED_S400;
        end
      end
    end
  end

  // ==========================================================================
  // Unstable flag, set wins over write-one-clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      unstable_reg <= 3'h0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (lineEvent[p].negFail || lineEvent[p].syncFail) begin
          unstable_reg[p] <= 1'b1;
        end else if (wrStrobe && addr_reg == OFS_PORT0 + 8'(4*p) && hwdata[POS_UNST]) begin
          unstable_reg[p] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Error tally, saturating, clear on read
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        tally_reg[p] <= 8'h00;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (rdStrobe && haddr[7:0] == OFS_TALLY0 + 8'(4*p)) begin
          tally_reg[p] <= lineEvent[p].badSymbol ? 8'h01 : 8'h00;
        end else if (lineEvent[p].badSymbol && tally_reg[p] != TALLY_MAX) begin
          tally_reg[p] <= tally_reg[p] + 8'h01;
        end
      end
    end
  end

  // ==========================================================================
  // Sleep permit: strap caught once after reset release, then software owned
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      permit_reg <= SLEEP_PERMIT_RESET;
      strapDone_reg <= 1'b0;
    end else if (!strapDone_reg) begin
      permit_reg <= {NUM_PORTS{sleepStrap}};
      strapDone_reg <= 1'b1;
    end else if (wrStrobe && addr_reg == OFS_SLEEP_PERMIT) begin
      permit_reg <= hwdata[2:0];
    end
  end

  // Dormant state entered on request only when permitted, held until the request drops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dormant_reg <= 3'h0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        dormant_reg[p] <= lineState[p].sleepReq && (permit_reg[p] || dormant_reg[p]);
      end
    end
  end

  // Dormant output
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      portDormant <= 3'h0;
    end else begin
      portDormant <= dormant_reg;
    end
  end

  // ==========================================================================
  // Interrupt: sticky per-port failure status, W1C, set wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irqStatus_reg <= 3'h0;
      irqMask_reg <= IRQ_MASK_RESET;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (lineEvent[p].negFail || lineEvent[p].syncFail) begin
          irqStatus_reg[p] <= 1'b1;
        end else if (wrStrobe && addr_reg == OFS_IRQ_STATUS && hwdata[p]) begin
          irqStatus_reg[p] <= 1'b0;
        end
      end
      if (wrStrobe && addr_reg == OFS_IRQ_MASK) begin
        irqMask_reg <= hwdata[2:0];
      end
    end
  end

  // Level interrupt
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

  // ==========================================================================
  // Checks
  ceil_clamp_a: assert property (@(posedge mclk) disable iff (!resetn)
    1'b1 |-> ceil_reg[1] <= capOf(1))
    else $error("ceiling above capability");
  bilingual_fixed_a: assert property (@(posedge mclk) disable iff (!resetn)
    !PORT_BONLY[0] |=> ceil_reg[0] == SPEED_S400)
    else $error("bilingual ceiling moved");
  unstable_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    (lineEvent[1].negFail || lineEvent[1].syncFail) |=> unstable_reg[1])
    else $error("unstable not set");
  unstable_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wrStrobe && addr_reg == OFS_PORT0 + 8'h04 && hwdata[POS_UNST] && !lineEvent[1].negFail
     && !lineEvent[1].syncFail) |=> !unstable_reg[1])
    else $error("unstable not cleared");
  tally_sat_a: assert property (@(posedge mclk) disable iff (!resetn)
    (tally_reg[0] == TALLY_MAX && !(rdStrobe && haddr[7:0] == OFS_TALLY0)) |=> tally_reg[0] == TALLY_MAX)
    else $error("tally wrapped");
  tally_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rdStrobe && haddr[7:0] == OFS_TALLY0 && !lineEvent[0].badSymbol) |=> tally_reg[0] == 8'h00)
    else $error("tally not cleared");
  tally_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rdStrobe && haddr[7:0] == OFS_TALLY0 && lineEvent[0].badSymbol) |=> tally_reg[0] == 8'h01)
    else $error("error lost on read clear");
  sleep_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!permit_reg[0] && !dormant_reg[0]) |=> !dormant_reg[0])
    else $error("sleep without permit");
  dormant_out_a: assert property (@(posedge mclk) disable iff (!resetn)
    dormant_reg[1] |=> portDormant[1])
    else $error("dormant flag missing");
  dormant_exit_a: assert property (@(posedge mclk) disable iff (!resetn)
    !lineState[1].sleepReq |=> !dormant_reg[1])
    else $error("dormant without sleep request");
  irq_level_a: assert property (@(posedge mclk) disable iff (!resetn)
    (irqStatus_reg & irqMask_reg) != 3'h0 |=> irq)
    else $error("interrupt missing");
  irq_quiet_a: assert property (@(posedge mclk) disable iff (!resetn)
    (irqStatus_reg & irqMask_reg) == 3'h0 |=> !irq)
    else $error("interrupt without cause");
  irq_status_a: assert property (@(posedge mclk) disable iff (!resetn)
    (lineEvent[1].negFail || lineEvent[1].syncFail) |=> irqStatus_reg[1])
    else $error("failure status not set");

  // Read data seen by software one cycle after the address phase, stored speed codes legal, tally counting
  plug_read_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rdStrobe && haddr[7:0] == OFS_PORT0) |=> hrdata[POS_PLUG])
    else $error("plug present flag low");
  cap_read_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rdStrobe && haddr[7:0] == OFS_PORT0 + 8'h04) |=> hrdata[POS_CAP +: 3] == capOf(1))
    else $error("capability field wrong");
  bsig_read_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rdStrobe && haddr[7:0] == OFS_PORT0) |=> hrdata[POS_BSIG] == $past(lineState[0].bSignaling))
    else $error("b signaling indicator wrong");
  legacy_read_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rdStrobe && haddr[7:0] == OFS_PORT0 && lineState[0].connected && lineState[0].receiveValid
     && !lineState[0].bSignaling) |=> hrdata[POS_LEGACY])
    else $error("legacy activity not shown");
  speed_legal_a: assert property (@(posedge mclk) disable iff (!resetn)
    1'b1 |-> ceil_reg[1] <= SPEED_TOP_LEGAL && ceil_reg[2] <= SPEED_TOP_LEGAL)
    else $error("reserved speed code stored");
  tally_count_a: assert property (@(posedge mclk) disable iff (!resetn)
    (lineEvent[0].badSymbol && tally_reg[0] != TALLY_MAX && !(rdStrobe && haddr[7:0] == OFS_TALLY0))
    |=> tally_reg[0] == $past(tally_reg[0]) + 8'h01)
    else $error("tally did not count");

  // Training speed only moves on a new connection
  train_speed_a: assert property (@(posedge mclk) disable iff (!resetn)
    (PORT_BONLY[1] && lineState[1].newBConn) |=> trainSpeed[5:3] == $past(ceil_reg[1]))
    else $error("training speed not taken from ceiling");
  train_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    !lineState[1].newBConn |=> $stable(trainSpeed[5:3]))
    else $error("training speed moved without connection");

  // Sleep permit from the strap, then from software
  strap_load_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(strapDone_reg) |-> permit_reg == {NUM_PORTS{$past(sleepStrap)}})
    else $error("sleep permit not loaded from strap");
  permit_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wrStrobe && addr_reg == OFS_SLEEP_PERMIT && strapDone_reg) |=> permit_reg == $past(hwdata[2:0]))
    else $error("sleep permit write lost");

  // Main scenarios
  unstable_cov_c: cover property (@(posedge mclk) disable iff (!resetn)
    lineEvent[1].negFail ##1 unstable_reg[1]);
  tally_cov_c: cover property (@(posedge mclk) disable iff (!resetn) tally_reg[0] == TALLY_MAX);
  sleep_cov_c: cover property (@(posedge mclk) disable iff (!resetn) $rose(portDormant[1]));
  train_cov_c: cover property (@(posedge mclk) disable iff (!resetn)
    lineState[1].newBConn ##1 trainSpeed[5:3] != SPEED_S400);
  irq_cov_c: cover property (@(posedge mclk) disable iff (!resetn) $rose(irq));
endmodule
`default_nettype wire

// ### tb/line_side_model.sv
// Line-side model: drives per-port line state and event pulses into the bank
`timescale 1ns/100ps
`default_nettype none
module line_side_model (
  input wire logic mclk,                                    // Bank clock
  output port_status_pkg::port_line_t [2:0] lineState,      // Line state per port
  output port_status_pkg::port_event_t [2:0] lineEvent      // Event pulses per port
);
  import port_status_pkg::*;

  // ==========================================================================
  // Quiet line at time zero
  initial begin
    lineState = '0;
    lineEvent = '0;
  end

  // Set one port's line levels just after an edge
  task automatic setLine(input int p, input logic [4:0] v);
    @(posedge mclk);
    lineState[p] <= v;
  endtask

  // One-cycle event pulses with a quiet cycle between them
  task automatic pulse(input int p, input logic [2:0] k, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      lineEvent[p] <= k;
      @(posedge mclk);
      lineEvent[p] <= 3'h0;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/serial_bus_port_status_fields_test.sv
// Self-checking testbench for the port status register bank
`timescale 1ns/100ps
`default_nettype none
module serial_bus_port_status_fields_test;
  import port_status_pkg::*;

  localparam logic [8:0] CAPS = {SPEED_S800, SPEED_S1600, SPEED_S400};
  logic mclk, resetn, hsel, hwrite, hreadyout, hresp, sleepStrap, irq;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize, portDormant;
  logic [8:0] trainSpeed;
  port_line_t [2:0] lineState;
  port_event_t [2:0] lineEvent;
  int fail_count = 0;
  int n_checks = 0;

  // ==========================================================================
  // Design and line model; ports 1 and 2 are B-only
  port_status_regs #(.PORT_CAP(CAPS), .PORT_BONLY(3'h6)) u_dut (.mclk(mclk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sleepStrap(sleepStrap), .lineState(lineState), .lineEvent(lineEvent),
    .trainSpeed(trainSpeed), .portDormant(portDormant), .irq(irq));
  line_side_model u_line (.mclk(mclk), .lineState(lineState), .lineEvent(lineEvent));

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ==========================================================================
  // Bus tasks and compare
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic wrr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] rd);
    xfer(1'b0, a, 32'h0, rd);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected port word with line state quiet
  function automatic logic [31:0] pw(input logic [2:0] ceil, input logic [2:0] cap, input logic permit);
    return {20'h0, permit, 4'h0, cap, 1'b1, ceil};
  endfunction

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #2000000;
    fail_count++;
    end_of_test;
  end

  // ==========================================================================
  // Test sequence
  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sleepStrap = 1'b1;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    // Reset values of every port word and the control words
    for (int p = 0; p < 3; p++) begin
      rdr(8'(4 * p), d);
      chk(d, pw(CAPS[3*p+:3], CAPS[3*p+:3], 1'b1));
    end
    rdr(8'h28, d);
    chk(d, 32'h7);
    rdr(8'h24, d);
    chk(d, 32'h0);
    rdr(8'h20, d);
    chk(d, 32'h0);
    chk(32'(hresp), 32'h0);
    chk(32'(hreadyout), 32'h1);
    // Every speed code on a B-only and on the bilingual port
    for (int c = 0; c < 8; c++) begin
      wrr(8'h04, 32'(c));
      rdr(8'h04, d);
      chk(32'(d[2:0]), (c > 4) ? 32'(SPEED_S1600) : 32'(c));
      wrr(8'h00, 32'(c));
      rdr(8'h00, d);
      chk(32'(d[2:0]), 32'(SPEED_S400));
    end
    // Ceiling only takes effect on a new B connection
    wrr(8'h04, 32'(SPEED_S200));
    repeat (3) @(posedge mclk);
    chk(32'(trainSpeed), 32'h092);
    for (int p = 0; p < 3; p++) begin
      u_line.setLine(p, 5'h01);
      u_line.setLine(p, 5'h00);
    end
    repeat (2) @(posedge mclk);
    chk(32'(trainSpeed), {23'h0, SPEED_S800, SPEED_S200, SPEED_S400});
    // Unstable flag, status, mask and interrupt
    u_line.pulse(1, 3'h4, 1);
    rdr(8'h04, d);
    chk(32'(d[7]), 32'h1);
    rdr(8'h20, d);
    chk(d, 32'h2);
    chk(32'(irq), 32'h0);
    wrr(8'h24, 32'h2);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h1);
    wrr(8'h04, 32'h81);
    rdr(8'h04, d);
    chk(32'(d[7]), 32'h0);
    wrr(8'h20, 32'h2);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0);
    u_line.pulse(2, 3'h2, 1);
    rdr(8'h08, d);
    chk(32'(d[7]), 32'h1);
    chk(32'(irq), 32'h0);
    // Mode indicators
    u_line.setLine(0, 5'h18);
    rdr(8'h00, d);
    chk(32'(d[10:8]), 32'h4);
    u_line.setLine(0, 5'h1c);
    rdr(8'h00, d);
    chk(32'(d[10:8]), 32'h1);
    u_line.setLine(0, 5'h00);
    rdr(8'h00, d);
    chk(32'(d[10:8]), 32'h0);
    // Error tally counts, saturates and clears on read
    u_line.pulse(0, 3'h1, 3);
    rdr(8'h10, d);
    chk(d, 32'h3);
    rdr(8'h10, d);
    chk(d, 32'h0);
    u_line.pulse(0, 3'h1, 260);
    rdr(8'h10, d);
    chk(d, 32'(TALLY_MAX));
    fork
      rdr(8'h10, d);
      u_line.pulse(0, 3'h1, 1);
    join
    chk(d, 32'h0);
    rdr(8'h10, d);
    chk(d, 32'h1);
    rdr(8'h18, d);
    chk(d, 32'h0);
    // Sleep only where permitted
    wrr(8'h28, 32'h6);
    u_line.setLine(0, 5'h02);
    u_line.setLine(1, 5'h02);
    repeat (3) @(posedge mclk);
    chk(32'(portDormant), 32'h2);
    rdr(8'h04, d);
    chk(32'(d[9]), 32'h1);
    rdr(8'h28, d);
    chk(d, 32'h6);
    u_line.setLine(0, 5'h00);
    u_line.setLine(1, 5'h00);
    repeat (3) @(posedge mclk);
    chk(32'(portDormant), 32'h0);
    // Second reset in mid-run with the strap low
    @(posedge mclk);
    sleepStrap <= 1'b0;
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rdr(8'h28, d);
    chk(d, 32'h0);
    rdr(8'h08, d);
    chk(d, pw(SPEED_S800, SPEED_S800, 1'b0));
    rdr(8'h24, d);
    chk(d, 32'h0);
    chk(32'(trainSpeed), 32'h092);
    // Unmapped place reads zero and ignores writes
    wrr(8'h3c, 32'hffffffff);
    rdr(8'h3c, d);
    chk(d, 32'h0);
    end_of_test;
  end
endmodule
`default_nettype wire
